// >>> lbf_fault_regs.v
/*
 * Fault status register bank: boost fault register and LED fault
 * register with latched flags, paired clear bits and read-only
 * detail flags.
 * Assumes fault event inputs are synchronous pulses or levels from the
 * fault detectors on core_clk_i, and a simple register port driven by
 * a host interface on the same clock.
 */
// Strobed register access was chosen for this implementation.
// Functional notes
// - Write one to flag and clear together
// - Boost bit 15 reports thermal shutdown
// - Bit 14 clears thermal flag
// - Bits 13/12 current resistor short flag/clear
// - Bits 11/10 string resistor missing flag/clear
// - Bits 9/8 mode resistor missing flag/clear
// - Bits 7/6 frequency resistor missing flag/clear
// - Bits 5/4 boost overcurrent flag/clear
// - Bits 3/2 high overvoltage flag/clear
// - Bit 1 low overvoltage flag
// - Bit 0 clears low overvoltage flag
// - LED bit 15 reserved, reads zero
// - Bits 14/13 serial timeout flag/clear
// - Bits 12/11 bad string config flag/clear
// - Bits 10/9 aggregate string fault flag/clear
// - Bit 8 read-only ground short detail
// - Bit 7 read-only internal short detail
// - Bit 6 read-only open string detail
// - Short and open clear with aggregate
`timescale 1ns/1ps
`include "lbf_map.vh"

module lbf_fault_regs (
    input  wire        core_clk_i,
    input  wire        resetn_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [15:0] reg_rdata_o,
    input  wire [7:0]  boost_fault_evt_i,
    input  wire        timeout_evt_i,
    input  wire        bad_cfg_evt_i,
    input  wire        ground_short_evt_i,
    input  wire        internal_short_evt_i,
    input  wire        open_string_evt_i,
    input  wire [3:0]  chan_fault_evt_i,
    output reg         fault_pending_o
);

    // ******************************************************************
    // Boost fault register
    // ******************************************************************
    // boost_fault_evt_i index: 7 thermal, 6 current resistor short,
    // 5 string resistor, 4 mode resistor, 3 frequency resistor,
    // 2 overcurrent, 1 high overvoltage, 0 low overvoltage.
    reg  [15:0] boost_fault_flags_r;
    wire        wr_boost;
    wire        wr_led;

    assign wr_boost = reg_wr_i && (reg_addr_i == `LBF_BOOST_OFS);
    assign wr_led   = reg_wr_i && (reg_addr_i == `LBF_LED_OFS);

    genvar g;
    generate
        for (g = 0; g < `LBF_B_NFAULT; g = g + 1) begin : g_boost
            wire clr_hit;
            assign clr_hit = wr_boost && reg_wdata_i[2*g+1]
                             && reg_wdata_i[2*g];
            // Flag sits at 2g+1 clear at 2g.
            always @(posedge core_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    boost_fault_flags_r[2*g+1] <= 1'b0;
                end else if (boost_fault_evt_i[g]) begin
                    boost_fault_flags_r[2*g+1] <= 1'b1;
                end else if (clr_hit) begin
                    boost_fault_flags_r[2*g+1] <= 1'b0;
                end
            end
            // The clear bit is storage only; a lone write of it keeps
            // the flag set, so software can read back what it wrote.
            always @(posedge core_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    boost_fault_flags_r[2*g] <= 1'b0;
                end else if (wr_boost) begin
                    boost_fault_flags_r[2*g] <= reg_wdata_i[2*g];
                end
            end
        end
    endgenerate

    // ******************************************************************
    // LED fault register
    // ******************************************************************
    reg         timeout_flag_r;
    reg         timeout_clr_r;
    reg         bad_cfg_flag_r;
    reg         bad_cfg_clr_r;
    reg         string_fault_flag_r;
    reg         string_fault_clr_r;
    reg         ground_short_r;
    reg         internal_short_r;
    reg         open_string_r;
    reg  [3:0]  chan_fault_r;
    wire        string_evt;
    wire        string_clr;
    wire [15:0] led_fault_flags;

    assign string_evt = ground_short_evt_i | internal_short_evt_i
                        | open_string_evt_i;
    assign string_clr = wr_led && reg_wdata_i[`LBF_L_STRING]
                        && reg_wdata_i[`LBF_L_STRING-1];

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timeout_flag_r      <= 1'b0;
            timeout_clr_r       <= 1'b0;
            bad_cfg_flag_r      <= 1'b0;
            bad_cfg_clr_r       <= 1'b0;
            string_fault_flag_r <= 1'b0;
            string_fault_clr_r  <= 1'b0;
        end else begin
            if (timeout_evt_i) begin
                timeout_flag_r <= 1'b1;
            end else if (wr_led && reg_wdata_i[`LBF_L_TIMEOUT]
                         && reg_wdata_i[`LBF_L_TIMEOUT-1]) begin
                timeout_flag_r <= 1'b0;
            end
            if (bad_cfg_evt_i) begin
                bad_cfg_flag_r <= 1'b1;
            end else if (wr_led && reg_wdata_i[`LBF_L_BADCFG]
                         && reg_wdata_i[`LBF_L_BADCFG-1]) begin
                bad_cfg_flag_r <= 1'b0;
            end
            if (string_evt) begin
                string_fault_flag_r <= 1'b1;
            end else if (string_clr) begin
                string_fault_flag_r <= 1'b0;
            end
            if (wr_led) begin
                timeout_clr_r      <= reg_wdata_i[`LBF_L_TIMEOUT-1];
                bad_cfg_clr_r      <= reg_wdata_i[`LBF_L_BADCFG-1];
                string_fault_clr_r <= reg_wdata_i[`LBF_L_STRING-1];
            end
        end
    end

    // Detail flags are read-only; only the aggregate clear write touches them.
    // Ground short is cleared with the aggregate too, so the detail
    // never outlives the summary flag that raised the indication.
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ground_short_r   <= 1'b0;
            internal_short_r <= 1'b0;
            open_string_r    <= 1'b0;
        end else begin
            if (ground_short_evt_i) begin
                ground_short_r <= 1'b1;
            end else if (string_clr) begin
                ground_short_r <= 1'b0;
            end
            if (internal_short_evt_i) begin
                internal_short_r <= 1'b1;
            end else if (string_clr) begin
                internal_short_r <= 1'b0;
            end
            if (open_string_evt_i) begin
                open_string_r <= 1'b1;
            end else if (string_clr) begin
                open_string_r <= 1'b0;
            end
        end
    end

    generate
        for (g = 0; g < `LBF_NCHAN; g = g + 1) begin : g_chan
            always @(posedge core_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    chan_fault_r[g] <= 1'b0;
                end else if (chan_fault_evt_i[g]) begin
                    chan_fault_r[g] <= 1'b1;
                end else if (string_clr) begin
                    chan_fault_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Bits 5:4 read zero whatever software writes there.
    assign led_fault_flags = {1'b0,
                              timeout_flag_r, timeout_clr_r,
                              bad_cfg_flag_r, bad_cfg_clr_r,
                              string_fault_flag_r, string_fault_clr_r,
                              ground_short_r, internal_short_r,
                              open_string_r, 2'b00,
                              chan_fault_r};

    // ******************************************************************
    // Read port and fault indication
    // ******************************************************************
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= `LBF_RST;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `LBF_BOOST_OFS) begin
                reg_rdata_o <= boost_fault_flags_r;
            end else if (reg_addr_i == `LBF_LED_OFS) begin
                reg_rdata_o <= led_fault_flags;
            end else begin
                reg_rdata_o <= `LBF_RST;
            end
        end else begin
            reg_rdata_o <= `LBF_RST;
        end
    end

    // Indication follows the latched boost flags and the three LED summary flags, not the channel flags, so the paired clear write
    // drops it in the cycle after the flag falls.
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_pending_o <= 1'b0;
        end else begin
            fault_pending_o <= (|(boost_fault_flags_r & 16'haaaa))
                               | timeout_flag_r | bad_cfg_flag_r
                               | string_fault_flag_r;
        end
    end

endmodule

// >>> lbf_map.vh
/*
 * Register map, field positions and reset values for the LED driver
 * fault status register bank.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef LBF_MAP_VH
`define LBF_MAP_VH

`define LBF_ADDR_W          8
`define LBF_DATA_W          16
`define LBF_BOOST_OFS       8'h10
`define LBF_LED_OFS         8'h12
`define LBF_RST             16'h0000

// Boost fault register: flag bit, clear bit one below.
`define LBF_B_THERMAL       15
`define LBF_B_ISET          13
`define LBF_B_STRRES        11
`define LBF_B_MODERES       9
`define LBF_B_FREQRES       7
`define LBF_B_OCP           5
`define LBF_B_OVPH          3
`define LBF_B_OVPL          1
`define LBF_B_NFAULT        8

// LED fault register fields.
`define LBF_L_RSVD          15
`define LBF_L_TIMEOUT       14
`define LBF_L_BADCFG        12
`define LBF_L_STRING        10
`define LBF_L_GND           8
`define LBF_L_SHORT         7
`define LBF_L_OPEN          6
`define LBF_L_RSVD_LO       4
`define LBF_L_CHAN0         0
`define LBF_NCHAN           4

`endif

// >>> lbf_fault_regs_properties.sv
/* Concurrent checks on the ports of the fault status register bank.
   Assumes one clock and the active-low asynchronous reset. */
`timescale 1ns/1ps
module lbf_fault_regs_chk (
    input logic        core_clk_i,
    input logic        resetn_i,
    input logic [7:0]  reg_addr_i,
    input logic [15:0] reg_wdata_i,
    input logic        reg_wr_i,
    input logic        reg_rd_i,
    input logic [15:0] reg_rdata_o,
    input logic [7:0]  boost_fault_evt_i,
    input logic        timeout_evt_i,
    input logic        ground_short_evt_i,
    input logic        open_string_evt_i,
    input logic [3:0]  chan_fault_evt_i,
    input logic        fault_pending_o
);
    // ********
    // Checks
    // ********
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    wire rd_b = reg_rd_i && reg_addr_i == 8'h10;
    wire rd_l = reg_rd_i && reg_addr_i == 8'h12;
    a_thermal_set: assert property (
        boost_fault_evt_i[7] ##1 !reg_wr_i ##1 rd_b |=> reg_rdata_o[15])
        else $error("thermal flag not set");
    a_ovpl_set: assert property (
        boost_fault_evt_i[0] ##1 !reg_wr_i ##1 rd_b |=> reg_rdata_o[1])
        else $error("low overvoltage flag not set");
    a_pending_rise: assert property (
        boost_fault_evt_i[7] |=> ##1 fault_pending_o)
        else $error("pending indication missing");
    // A flag only drops on a write, so the indication may not fall without one.
    a_pending_hold: assert property (
        fault_pending_o && !reg_wr_i && !$past(reg_wr_i) |=> fault_pending_o)
        else $error("pending indication fell without a write");
    a_led_rsvd: assert property (
        rd_l |=> !reg_rdata_o[15] && reg_rdata_o[5:4] == 2'b00)
        else $error("reserved bits not zero");
    a_timeout_set: assert property (
        timeout_evt_i ##1 !reg_wr_i ##1 rd_l |=> reg_rdata_o[14])
        else $error("timeout flag not set");
    a_open_detail: assert property (
        open_string_evt_i ##1 !reg_wr_i ##1 rd_l
        |=> reg_rdata_o[10] && reg_rdata_o[6])
        else $error("open detail or aggregate missing");
    a_ground_detail: assert property (
        ground_short_evt_i ##1 !reg_wr_i ##1 rd_l
        |=> reg_rdata_o[8] && reg_rdata_o[10])
        else $error("ground detail missing");
    a_chan_set: assert property (
        chan_fault_evt_i[0] ##1 !reg_wr_i ##1 rd_l |=> reg_rdata_o[0])
        else $error("channel flag missing");
    c_clear: cover property (reg_wr_i && reg_wdata_i[15:14] == 2'b11);
    c_fall: cover property ($fell(fault_pending_o));
    c_led: cover property (rd_l ##1 reg_rdata_o != 16'h0000);
endmodule

bind lbf_fault_regs lbf_fault_regs_chk i_chk (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .boost_fault_evt_i(boost_fault_evt_i),
    .timeout_evt_i(timeout_evt_i), .ground_short_evt_i(ground_short_evt_i),
    .open_string_evt_i(open_string_evt_i),
    .chan_fault_evt_i(chan_fault_evt_i), .fault_pending_o(fault_pending_o));

// >>> tb_top.sv
/* Self-checking bench for the fault status register bank.
   Drives the register port and the fault inputs directly. */
`timescale 1ns/1ps
module tb_top;
    logic        core_clk_i = 1'b0;
    logic        resetn_i   = 1'b0;
    logic [7:0]  addr       = 8'h00;
    logic [15:0] wdata      = 16'h0000;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic [7:0]  bevt       = 8'h00;
    logic [4:0]  levt       = 5'h00;
    logic [3:0]  chev       = 4'h0;
    wire  [15:0] rdata;
    wire         pend;
    int          n_errors   = 0;
    int          checks     = 0;
    int          cyc        = 0;
    lbf_fault_regs i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .boost_fault_evt_i(bevt),
        .timeout_evt_i(levt[4]), .bad_cfg_evt_i(levt[3]),
        .ground_short_evt_i(levt[2]), .internal_short_evt_i(levt[1]),
        .open_string_evt_i(levt[0]), .chan_fault_evt_i(chev),
        .fault_pending_o(pend));
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    // ********
    // Tasks
    // ********
    task end_sim;
        $display("Checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so look mid-cycle.
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        @(negedge core_clk_i);
        chk(rdata, exp);
    endtask
    task automatic fire(input logic [7:0] b, input logic [4:0] l,
                        input logic [3:0] c);
        @(posedge core_clk_i);
        bevt <= b;
        levt <= l;
        chev <= c;
        @(posedge core_clk_i);
        bevt <= 8'h00;
        levt <= 5'h00;
        chev <= 4'h0;
    endtask
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            end_sim;
        end
    end
    // ********
    // Sequence
    // ********
    initial begin
        repeat (5) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rd_reg(8'h10, 16'h0000);
        rd_reg(8'h12, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            fire(8'h01 << i, 5'h00, 4'h0);
            wr_reg(8'h10, 16'h0001 << (2 * i));
            rd_reg(8'h10, 16'h0003 << (2 * i));
            chk({15'h0000, pend}, 16'h0001);
            wr_reg(8'h10, 16'h0003 << (2 * i));
            rd_reg(8'h10, 16'h0001 << (2 * i));
            chk({15'h0000, pend}, 16'h0000);
        end
        fire(8'h81, 5'h00, 4'h0);
        rd_reg(8'h10, 16'hc002);
        wr_reg(8'h10, 16'haaaa);
        rd_reg(8'h10, 16'h8002);
        wr_reg(8'h10, 16'hffff);
        rd_reg(8'h10, 16'h5555);
        wr_reg(8'h10, 16'h0000);
        fire(8'h00, 5'h1f, 4'hf);
        rd_reg(8'h12, 16'h55cf);
        wr_reg(8'h12, 16'h81cf);
        rd_reg(8'h12, 16'h55cf);
        wr_reg(8'h12, 16'h6000);
        rd_reg(8'h12, 16'h35cf);
        wr_reg(8'h12, 16'h1a00);
        rd_reg(8'h12, 16'h0fcf);
        wr_reg(8'h12, 16'h0600);
        rd_reg(8'h12, 16'h0200);
        chk({15'h0000, pend}, 16'h0000);
        wr_reg(8'h14, 16'hffff);
        rd_reg(8'h14, 16'h0000);
        rd_reg(8'h12, 16'h0200);
        end_sim;
    end
endmodule
